// >>> hw/ppe_pkg.sv
`default_nettype none
package ppe_pkg;
  // ---------------------------------------------------------------------------
  // Serial commands
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_UNLOCK   = 8'h06;
  localparam logic [7:0] OP_PAGE_WRITE     = 8'h02;
  localparam logic [7:0] OP_PAGE_WRITE_W   = 8'h12;
  localparam logic [7:0] OP_READ_STATUS    = 8'h05;
  localparam logic [7:0] OP_READ_DATA      = 8'h03;
  localparam logic [7:0] OP_CORR_STATUS    = 8'h19;
  localparam logic [7:0] OP_SECTOR_ERASE   = 8'hd8;
  localparam logic [7:0] OP_CLEAR_STATUS   = 8'h30;
  // ---------------------------------------------------------------------------
  // Status fields and geometry
  // ---------------------------------------------------------------------------
  localparam int ST_BUSY       = 0;
  localparam int ST_LATCH      = 1;
  localparam int ST_PERR       = 6;
  localparam int CS_DISABLED   = 0;
  localparam int CS_DATA_FIX   = 1;
  localparam int CS_CHECK_FIX  = 2;
  localparam int CS_BLANK      = 3;
  localparam int UNIT_BYTES    = 16;
  localparam int PAGE_UNITS    = 32;
  localparam int CHECK_W       = 8;
  // ---------------------------------------------------------------------------
  // APB map
  // ---------------------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_CORR   = 12'h008;
  localparam logic [11:0] ADDR_FIXCNT = 12'h00c;
  localparam int          CTRL_WIDE   = 0;
  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int PROG_TIME_NS  = 2000;
  localparam int ERASE_TIME_NS = 4000;
  localparam int PROG_MIN_CYC  = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_MIN_CYC = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {SPI_OP, SPI_ADDR, SPI_DIN, SPI_DOUT, SPI_ARMED, SPI_IGNORE}
    ppe_spi_state_type;
  typedef enum logic [1:0] {CMD_PROG, CMD_READ, CMD_CORR, CMD_STATUS} ppe_cmd_type;
  typedef enum logic [1:0] {OPS_IDLE, OPS_PROG, OPS_ERASE, OPS_WAIT} ppe_op_state_type;
  typedef struct packed {
    logic [7:0] check;
    logic       disabled;
    logic       used;
  } ppe_meta_type;
  localparam ppe_meta_type META_ERASED = '{check: 8'hff, disabled: 1'b0, used: 1'b0};
endpackage
`default_nettype wire

// >>> hw/ppe_page_program_ecc.sv
`timescale 1ns/100ps
`default_nettype none
module ppe_page_program_ecc #(
  parameter int MEM_UNITS    = 256,
  parameter int SECTOR_UNITS = 64,
  parameter int OTP_UNITS    = 64
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        si,
  output var  logic        so,
  output var  logic        so_oe,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr
);
  localparam int UA_W = $clog2(MEM_UNITS);
  localparam int SU_W = $clog2(SECTOR_UNITS);

  // ---------------------------------------------------------------------------
  // Check code
  // ---------------------------------------------------------------------------
  // Each data bit owns a distinct column of weight two or more, so a syndrome of
  // weight one points at a check bit and any other nonzero one that matches a column at a data bit.
  function automatic logic [7:0] ecc_calc(input logic [127:0] d);
    logic [7:0] c;
    logic [7:0] v;
    c = 8'h00;
    v = 8'h02;
    for (int i = 0; i < 128; i++) begin
      v = v + 8'h01;
      if ((v & (v - 8'h01)) == 8'h00) v = v + 8'h01;
      if (d[i]) c = c ^ v;
    end
    return c;
  endfunction

  function automatic logic [127:0] ecc_fix(input logic [127:0] d, input logic [7:0] syn);
    logic [127:0] r;
    logic [7:0]   v;
    r = d;
    v = 8'h02;
    for (int i = 0; i < 128; i++) begin
      v = v + 8'h01;
      if ((v & (v - 8'h01)) == 8'h00) v = v + 8'h01;
      if (v == syn) r[i] = ~d[i];
    end
    return r;
  endfunction

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [2:0] sck_sync_reg;
  logic [2:0] cs_sync_reg;
  logic [1:0] si_sync_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sck_sync_reg <= 3'h0;
      cs_sync_reg  <= 3'h7;
      si_sync_reg  <= 2'h0;
    end else begin
      sck_sync_reg <= {sck_sync_reg[1:0], sck};
      cs_sync_reg  <= {cs_sync_reg[1:0], cs_n};
      si_sync_reg  <= {si_sync_reg[0], si};
    end
  end

  wire cs_high = cs_sync_reg[1];
  wire cs_rise = cs_sync_reg[1] & ~cs_sync_reg[2];
  wire sample  = sck_sync_reg[1] & ~sck_sync_reg[2] & ~cs_high;
  wire shift   = ~sck_sync_reg[1] & sck_sync_reg[2] & ~cs_high;

  // ---------------------------------------------------------------------------
  // Registers and storage
  // ---------------------------------------------------------------------------
  ppe_pkg::ppe_spi_state_type spi_state_reg;
  ppe_pkg::ppe_cmd_type       cmd_reg;
  ppe_pkg::ppe_op_state_type  op_state_reg;
  ppe_pkg::ppe_meta_type      meta_reg [MEM_UNITS];
  logic [127:0] mem_reg [MEM_UNITS];
  logic [127:0] pbuf_reg [ppe_pkg::PAGE_UNITS];
  logic [31:0]  touched_reg;
  logic [2:0]   bit_cnt_reg;
  logic [6:0]   in_shift_reg;
  logic [7:0]   out_shift_reg;
  logic [31:0]  addr_reg;
  logic [31:0]  rd_addr_reg;
  logic [1:0]   addr_left_reg;
  logic [8:0]   ptr_reg;
  logic         got_data_reg;
  logic         out_load_reg;
  logic         is_erase_reg;
  logic         unlock_latch_reg;
  logic         perr_reg;
  logic         wide_reg;
  logic [15:0]  step_reg;
  logic [15:0]  busy_cnt_reg;
  logic [7:0]   last_corr_reg;
  logic [15:0]  fix_cnt_reg;
  logic         so_reg;
  logic         so_oe_reg;
  logic [31:0]  prdata_reg;
  logic         pready_reg;
  logic         pslverr_reg;

  // ---------------------------------------------------------------------------
  // Byte framing and command decode
  // ---------------------------------------------------------------------------
  wire [7:0] byte_in   = {in_shift_reg, si_sync_reg[1]};
  wire       byte_done = sample && (bit_cnt_reg == 3'h7);
  wire       op_busy   = (op_state_reg != ppe_pkg::OPS_IDLE);
  wire [7:0] status1   = {1'b0, perr_reg, 4'h0, unlock_latch_reg, op_busy};
  wire       is_pw     = (byte_in == ppe_pkg::OP_PAGE_WRITE);
  wire       is_pw_w   = (byte_in == ppe_pkg::OP_PAGE_WRITE_W);
  wire       is_erase  = (byte_in == ppe_pkg::OP_SECTOR_ERASE);
  wire       is_read   = (byte_in == ppe_pkg::OP_READ_DATA);
  wire       is_corr   = (byte_in == ppe_pkg::OP_CORR_STATUS);
  wire       write_ok  = unlock_latch_reg & ~op_busy;
  wire       addr_done = byte_done && (spi_state_reg == ppe_pkg::SPI_ADDR)
                         && (addr_left_reg == 2'h0);
  wire [31:0] addr_full = {addr_reg[23:0], byte_in};
  wire       latch_set = byte_done && (spi_state_reg == ppe_pkg::SPI_OP) && ~op_busy
                         && (byte_in == ppe_pkg::OP_WRITE_UNLOCK);
  wire       perr_clr  = byte_done && (spi_state_reg == ppe_pkg::SPI_OP) && ~op_busy
                         && (byte_in == ppe_pkg::OP_CLEAR_STATUS);
  wire       din_byte  = byte_done && (spi_state_reg == ppe_pkg::SPI_DIN);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt_reg  <= 3'h0;
      in_shift_reg <= 7'h00;
    end else if (cs_high) begin
      bit_cnt_reg  <= 3'h0;
    end else if (sample) begin
      bit_cnt_reg  <= bit_cnt_reg + 3'h1;
      in_shift_reg <= byte_in[6:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      spi_state_reg <= ppe_pkg::SPI_OP;
      cmd_reg       <= ppe_pkg::CMD_STATUS;
      addr_reg      <= 32'h0;
      addr_left_reg <= 2'h0;
      is_erase_reg  <= 1'b0;
      out_load_reg  <= 1'b0;
    end else begin
      out_load_reg <= 1'b0;
      if (cs_high) begin
        spi_state_reg <= ppe_pkg::SPI_OP;
      end else if (byte_done) begin
        unique case (spi_state_reg)
          ppe_pkg::SPI_OP: begin
            addr_reg      <= 32'h0;
            is_erase_reg  <= is_erase;
            addr_left_reg <= (is_pw_w || wide_reg) ? 2'h3 : 2'h2;
            spi_state_reg <= ppe_pkg::SPI_IGNORE;
            if (byte_in == ppe_pkg::OP_READ_STATUS) begin
              cmd_reg       <= ppe_pkg::CMD_STATUS;
              out_load_reg  <= 1'b1;
              spi_state_reg <= ppe_pkg::SPI_DOUT;
            end else if ((is_pw || is_erase) && write_ok) begin
              cmd_reg       <= ppe_pkg::CMD_PROG;
              spi_state_reg <= ppe_pkg::SPI_ADDR;
            end else if (is_pw_w && write_ok) begin
              cmd_reg       <= ppe_pkg::CMD_PROG;
              spi_state_reg <= ppe_pkg::SPI_ADDR;
            end else if ((is_read || is_corr) && ~op_busy) begin
              cmd_reg       <= is_read ? ppe_pkg::CMD_READ : ppe_pkg::CMD_CORR;
              spi_state_reg <= ppe_pkg::SPI_ADDR;
            end
          end
          ppe_pkg::SPI_ADDR: begin
            addr_reg      <= addr_full;
            addr_left_reg <= addr_left_reg - 2'h1;
            if (addr_left_reg == 2'h0) begin
              if (cmd_reg != ppe_pkg::CMD_PROG) begin
                out_load_reg  <= 1'b1;
                spi_state_reg <= ppe_pkg::SPI_DOUT;
              end else begin
                spi_state_reg <= is_erase_reg ? ppe_pkg::SPI_ARMED : ppe_pkg::SPI_DIN;
              end
            end
          end
          ppe_pkg::SPI_DOUT: out_load_reg <= 1'b1;
          ppe_pkg::SPI_DIN, ppe_pkg::SPI_ARMED, ppe_pkg::SPI_IGNORE: ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Page buffer
  // ---------------------------------------------------------------------------
  // one frame to one page
  wire pw_accept = byte_done && (spi_state_reg == ppe_pkg::SPI_OP) && write_ok
                   && (is_pw || is_pw_w);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int u = 0; u < ppe_pkg::PAGE_UNITS; u++) pbuf_reg[u] <= '1;
      touched_reg  <= 32'h0;
      ptr_reg      <= 9'h000;
      got_data_reg <= 1'b0;
    end else if (pw_accept) begin
      for (int u = 0; u < ppe_pkg::PAGE_UNITS; u++) pbuf_reg[u] <= '1;
      touched_reg  <= 32'h0;
      got_data_reg <= 1'b0;
    end else if (addr_done && (cmd_reg == ppe_pkg::CMD_PROG)) begin
      ptr_reg <= addr_full[8:0];
    end else if (din_byte) begin
      pbuf_reg[ptr_reg[8:4]][{ptr_reg[3:0], 3'b000} +: 8] <= byte_in;
      touched_reg[ptr_reg[8:4]] <= 1'b1;
      got_data_reg <= 1'b1;
      ptr_reg <= ptr_reg + 9'h001;
    end
  end

  // ---------------------------------------------------------------------------
  // Internal program and erase sequencer
  // ---------------------------------------------------------------------------
  wire [UA_W-1:0] pu       = {addr_reg[UA_W+3:9], step_reg[4:0]};
  wire [UA_W-1:0] eu       = {addr_reg[UA_W+3:SU_W+4], step_reg[SU_W-1:0]};
  wire            addr_bad = |addr_reg[31:UA_W+4];
  wire            in_otp   = (addr_reg[UA_W+3:4] >= UA_W'(MEM_UNITS - OTP_UNITS));
  wire prog_start = cs_rise && (spi_state_reg == ppe_pkg::SPI_DIN) && got_data_reg;
  wire erase_start = cs_rise && (spi_state_reg == ppe_pkg::SPI_ARMED);
  wire start_fail  = (prog_start && addr_bad) || (erase_start && (addr_bad || in_otp));
  wire prog_we     = (op_state_reg == ppe_pkg::OPS_PROG) && touched_reg[step_reg[4:0]];
  wire erase_we    = (op_state_reg == ppe_pkg::OPS_ERASE);
  wire op_done     = (op_state_reg == ppe_pkg::OPS_WAIT) && (busy_cnt_reg == 16'h0);
  wire [127:0] old_word = mem_reg[pu];
  // bits only go from one to zero
  wire [127:0] new_word = old_word & pbuf_reg[step_reg[4:0]];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      op_state_reg <= ppe_pkg::OPS_IDLE;
      step_reg     <= 16'h0;
      busy_cnt_reg <= 16'h0;
    end else begin
      if (busy_cnt_reg != 16'h0) busy_cnt_reg <= busy_cnt_reg - 16'h1;
      step_reg <= step_reg + 16'h1;
      unique case (op_state_reg)
        ppe_pkg::OPS_IDLE: begin
          step_reg <= 16'h0;
          if (prog_start && !start_fail) begin
            op_state_reg <= ppe_pkg::OPS_PROG;
            busy_cnt_reg <= 16'(ppe_pkg::PROG_MIN_CYC);
          end else if (erase_start && !start_fail) begin
            op_state_reg <= ppe_pkg::OPS_ERASE;
            busy_cnt_reg <= 16'(ppe_pkg::ERASE_MIN_CYC);
          end
        end
        ppe_pkg::OPS_PROG:
          if (step_reg == 16'(ppe_pkg::PAGE_UNITS - 1)) op_state_reg <= ppe_pkg::OPS_WAIT;
        ppe_pkg::OPS_ERASE:
          if (step_reg == 16'(SECTOR_UNITS - 1)) op_state_reg <= ppe_pkg::OPS_WAIT;
        ppe_pkg::OPS_WAIT:
          if (op_done) op_state_reg <= ppe_pkg::OPS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      unlock_latch_reg <= 1'b0;
      perr_reg         <= 1'b0;
    end else begin
      if (latch_set) unlock_latch_reg <= 1'b1;
      else if (op_done || start_fail) unlock_latch_reg <= 1'b0;
      if (start_fail && prog_start) perr_reg <= 1'b1;
      else if (perr_clr) perr_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int u = 0; u < MEM_UNITS; u++) begin
        mem_reg[u]  <= '1;
        meta_reg[u] <= ppe_pkg::META_ERASED;
      end
    end else if (prog_we) begin
      mem_reg[pu] <= new_word;
      if (meta_reg[pu].used)
        meta_reg[pu] <= '{check: 8'h00, disabled: 1'b1, used: 1'b1};
      else
        meta_reg[pu] <= '{check: ecc_calc(new_word), disabled: 1'b0, used: 1'b1};
    end else if (erase_we) begin
      mem_reg[eu]  <= '1;
      meta_reg[eu] <= ppe_pkg::META_ERASED;
    end
  end

  // ---------------------------------------------------------------------------
  // Read path with correction
  // ---------------------------------------------------------------------------
  wire [UA_W-1:0]        ru      = rd_addr_reg[UA_W+3:4];
  wire [127:0]           rword   = mem_reg[ru];
  wire ppe_pkg::ppe_meta_type rmeta = meta_reg[ru];
  wire                   corr_on = rmeta.used & ~rmeta.disabled;
  wire [7:0]             syn     = ecc_calc(rword) ^ rmeta.check;
  wire                   syn_one = (syn != 8'h00) && ((syn & (syn - 8'h01)) == 8'h00);
  wire                   data_fix = corr_on && (syn != 8'h00) && !syn_one;
  wire                   chk_fix  = corr_on && syn_one;
  wire [127:0]           fixed   = corr_on ? ecc_fix(rword, syn) : rword;
  wire [7:0]             rd_byte = (|rd_addr_reg[31:UA_W+4]) ? 8'hff
                                   : fixed[{rd_addr_reg[3:0], 3'b000} +: 8];
  wire [7:0]             corr_byte = {4'h0, ~rmeta.used, chk_fix, data_fix, rmeta.disabled};
  wire [7:0]             out_src = (cmd_reg == ppe_pkg::CMD_STATUS) ? status1
                                   : (cmd_reg == ppe_pkg::CMD_CORR) ? corr_byte : rd_byte;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_addr_reg   <= 32'h0;
      out_shift_reg <= 8'h00;
      so_reg        <= 1'b0;
      so_oe_reg     <= 1'b0;
      last_corr_reg <= 8'h00;
      fix_cnt_reg   <= 16'h0;
    end else begin
      so_oe_reg <= ~cs_high && (spi_state_reg == ppe_pkg::SPI_DOUT);
      if (addr_done) rd_addr_reg <= addr_full;
      if (out_load_reg) begin
        out_shift_reg <= out_src;
        if (cmd_reg == ppe_pkg::CMD_READ) begin
          rd_addr_reg <= rd_addr_reg + 32'h1;
          if (data_fix || chk_fix) begin
            fix_cnt_reg   <= fix_cnt_reg + 16'h1;
            last_corr_reg <= corr_byte;
          end
        end else if (cmd_reg == ppe_pkg::CMD_CORR) begin
          last_corr_reg <= corr_byte;
        end
      end else if (shift && (spi_state_reg == ppe_pkg::SPI_DOUT)) begin
        so_reg        <= out_shift_reg[7];
        out_shift_reg <= {out_shift_reg[6:0], 1'b0};
      end
    end
  end

  // ---------------------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------------------
  wire        apb_req  = psel && penable && !pready_reg;
  wire        apb_done = psel && penable && pready_reg;
  wire        hit_ctrl = (paddr == ppe_pkg::ADDR_CTRL);
  wire        hit_any  = hit_ctrl || (paddr == ppe_pkg::ADDR_STATUS)
                         || (paddr == ppe_pkg::ADDR_CORR) || (paddr == ppe_pkg::ADDR_FIXCNT);
  wire [31:0] rd_mux   = hit_ctrl ? {31'h0, wide_reg}
                         : (paddr == ppe_pkg::ADDR_STATUS) ? {24'h0, status1}
                         : (paddr == ppe_pkg::ADDR_CORR) ? {24'h0, last_corr_reg}
                         : (paddr == ppe_pkg::ADDR_FIXCNT) ? {16'h0, fix_cnt_reg} : 32'h0;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
      wide_reg    <= 1'b0;
    end else begin
      pready_reg  <= apb_req;
      pslverr_reg <= apb_req && (!hit_any || (pwrite && !hit_ctrl));
      if (apb_req && !pwrite) prdata_reg <= rd_mux;
      if (apb_done && pwrite && hit_ctrl && pstrb[0]) wide_reg <= pwdata[ppe_pkg::CTRL_WIDE];
    end
  end

  assign so      = so_reg;
  assign so_oe   = so_oe_reg;
  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking ppe_cb @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_BUSY_WHILE_OP: assert property (
    (op_state_reg != ppe_pkg::OPS_IDLE) |-> status1[ppe_pkg::ST_BUSY]
  ) else $error("busy bit low during an operation");
  AST_START_ON_CS: assert property (
    (op_state_reg == ppe_pkg::OPS_IDLE) ##1 (op_state_reg == ppe_pkg::OPS_PROG)
      |-> $past(cs_rise) && $past(got_data_reg)
  ) else $error("program started without chip select rise");
  AST_LATCH_CLEARED: assert property (
    op_done |=> !unlock_latch_reg && (op_state_reg == ppe_pkg::OPS_IDLE)
  ) else $error("write latch not cleared at finish");
  AST_NEED_UNLOCK: assert property (
    pw_accept |-> unlock_latch_reg ##1 (spi_state_reg == ppe_pkg::SPI_ADDR)
  ) else $error("page write accepted without latch");
  AST_ONLY_CLEAR: assert property (
    prog_we |=> ((mem_reg[$past(pu)] & ~$past(old_word)) == 128'h0)
  ) else $error("program raised a bit");
  AST_SECOND_DISABLES: assert property (
    (prog_we && meta_reg[pu].used) |=> meta_reg[$past(pu)].disabled
  ) else $error("second program left correction on");
  AST_ERASE_ENABLES: assert property (
    erase_we |=> !meta_reg[$past(eu)].disabled && !meta_reg[$past(eu)].used
  ) else $error("erase left unit disabled");
  AST_OTP_KEPT: assert property (
    (op_state_reg == ppe_pkg::OPS_ERASE) |-> !in_otp
  ) else $error("erase reached the one-time region");
  AST_PAGE_WRAP: assert property (
    (din_byte && (ptr_reg == 9'h1ff)) |=> (ptr_reg == 9'h000)
  ) else $error("pointer left the page");
  AST_RAW_READ: assert property (
    (rmeta.disabled && !(|rd_addr_reg[31:UA_W+4]))
      |-> (rd_byte == rword[{rd_addr_reg[3:0], 3'b000} +: 8]) && !data_fix && !chk_fix
  ) else $error("disabled unit was corrected");
  AST_PERR_SET: assert property (
    (prog_start && addr_bad && (op_state_reg == ppe_pkg::OPS_IDLE)) |=> perr_reg [*2]
  ) else $error("error flag not raised");

  COV_PROGRAM: cover property (op_state_reg == ppe_pkg::OPS_PROG ##[400:600] op_done);
  COV_ERASE:   cover property (erase_we);
  COV_FIX:     cover property (out_load_reg && data_fix);
  COV_REPROG:  cover property (prog_we && meta_reg[pu].used);
endmodule
`default_nettype wire

// >>> testbench/ppe_spi_host.sv
`timescale 1ns/100ps
`default_nettype none
module ppe_spi_host (
  output var  logic sck,
  output var  logic cs_n,
  output var  logic si,
  input  wire logic so
);
  logic [7:0] rx;
  event       rx_ev;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  task automatic xb(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      si = d[i];
      #62.5 sck = 1'b1;
      q[i] = so;
      #62.5 sck = 1'b0;
    end
  endtask
  task automatic frame(input logic [7:0] tx[$], input int nrx);
    logic [7:0] b;
    // Frames start 0.3 ns after a whole nanosecond and last whole nanoseconds,
    // so no pin ever moves on a clock edge.
    #0.3 cs_n = 1'b0;
    foreach (tx[k]) xb(tx[k], b);
    repeat (nrx) begin
      xb(~b, b);
      rx = b;
      ->rx_ev;
    end
    #62.5 cs_n = 1'b1;
    // The released line shows the inverse of its last bit.
    si = ~si;
    #437.2;
  endtask
endmodule
`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb;
  localparam logic [11:0] ST = ppe_pkg::ADDR_STATUS;
  localparam logic [7:0]  RD = ppe_pkg::OP_READ_DATA;
  localparam logic [7:0]  CR = ppe_pkg::OP_CORR_STATUS;
  logic        clk, nrst, psel, penable, pwrite, so, so_oe, pready, pslverr, poll;
  logic        sck, cs_n, si;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic [32:0] qa[$];
  logic [7:0]  qs[$];
  logic [7:0]  tx[$];
  int          fails, n_compared;
  ppe_page_program_ecc uut (.clk(clk), .nrst(nrst), .sck(sck), .cs_n(cs_n), .si(si),
    .so(so), .so_oe(so_oe), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  // An undriven data line reads as the inverse of its last bit.
  wire         so_line = so_oe ? so : ~so;
  ppe_spi_host host (.sck(sck), .cs_n(cs_n), .si(si), .so(so_line));
  always #2 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [32:0] e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= e[31:0];
    if (!w && !poll) qa.push_back(e);
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic prog(input logic [7:0] tx[$]);
    host.frame('{ppe_pkg::OP_WRITE_UNLOCK}, 0);
    apb(1'b0, ST, 33'h2);
    host.frame(tx, 0);
    apb(1'b0, ST, 33'h3);
    @(posedge clk);
    poll = 1'b1;
    do apb(1'b0, ST, '0); while (prdata[0] !== 1'b0);
    @(posedge clk);
    poll = 1'b0;
    apb(1'b0, ST, 33'h0);
    $display("program test done");
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) if (psel && penable && pready && !pwrite && !poll)
    `CHK({pslverr, prdata}, qa.pop_front())
  always @(host.rx_ev) `CHK(host.rx, qs.pop_front())
  initial begin
    #200000;
    fails++;
    wrap_up();
  end
  initial begin
    {clk, nrst, psel, penable, pwrite, paddr, pwdata, poll} = '0;
    rnd = lfsr(32'h1672);
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, ST, 33'h0);
    apb(1'b0, 12'h010, 33'h1_0000_0000);
    host.frame('{ppe_pkg::OP_PAGE_WRITE, 8'h00, 8'h00, 8'h01, 8'h00}, 0);
    prog('{ppe_pkg::OP_PAGE_WRITE, 8'h00, 8'h01, 8'hff, rnd[7:0], rnd[15:8]});
    qs = '{8'hff, rnd[7:0], rnd[15:8], 8'hff, 8'h00};
    host.frame('{RD, 8'h00, 8'h01, 8'hfe}, 2);
    host.frame('{RD, 8'h00, 8'h00, 8'h00}, 2);
    host.frame('{CR, 8'h00, 8'h00, 8'h00}, 1);
    prog('{ppe_pkg::OP_PAGE_WRITE, 8'h00, 8'h00, 8'h00, rnd[23:16]});
    qs = '{rnd[15:8] & rnd[23:16], 8'h01};
    host.frame('{RD, 8'h00, 8'h00, 8'h00}, 1);
    host.frame('{CR, 8'h00, 8'h00, 8'h00}, 1);
    apb(1'b0, ppe_pkg::ADDR_CORR, 33'h1);
    $display("correction test done");
    host.frame('{ppe_pkg::OP_WRITE_UNLOCK}, 0);
    host.frame('{ppe_pkg::OP_PAGE_WRITE_W, 8'h00, 8'h00, 8'h10, 8'h00, rnd[31:24]}, 0);
    qs = '{8'h40};
    host.frame('{ppe_pkg::OP_READ_STATUS}, 1);
    host.frame('{ppe_pkg::OP_CLEAR_STATUS}, 0);
    apb(1'b0, ST, 33'h0);
    $display("error test done");
    apb(1'b1, ppe_pkg::ADDR_CTRL, 33'h1);
    apb(1'b0, ppe_pkg::ADDR_CTRL, 33'h1);
    prog('{ppe_pkg::OP_SECTOR_ERASE, 8'h00, 8'h00, 8'h00, 8'h00});
    qs = '{8'hff, 8'h08};
    host.frame('{RD, 8'h00, 8'h00, 8'h00, 8'h00}, 1);
    host.frame('{CR, 8'h00, 8'h00, 8'h00, 8'h00}, 1);
    host.frame('{ppe_pkg::OP_WRITE_UNLOCK}, 0);
    host.frame('{ppe_pkg::OP_SECTOR_ERASE, 8'h00, 8'h00, 8'h0c, 8'h00}, 0);
    apb(1'b0, ST, 33'h0);
    $display("erase test done");
    tx = '{ppe_pkg::OP_PAGE_WRITE, 8'h00, 8'h00, 8'h00, 8'h10};
    repeat (16) begin
      rnd = lfsr(rnd);
      tx.push_back(rnd[7:0]);
    end
    prog(tx);
    qs = '{tx[5], tx[6], 8'h00};
    host.frame('{RD, 8'h00, 8'h00, 8'h00, 8'h10}, 2);
    host.frame('{CR, 8'h00, 8'h00, 8'h00, 8'h10}, 1);
    $display("aligned test done");
    wrap_up();
  end
endmodule
`default_nettype wire
